// >>> rtl/bus_dp_pkg.sv
// shared constants and types for the data-phase bus block
// assumes both ends run on core_clk_in and share this package
package bus_dp_pkg;
    localparam int DATA_W  = 64;
    localparam int LANES   = DATA_W / 8;
    localparam int ADDR_W  = 32;
    localparam int SNOOP_LO = 5;
    localparam int BURST_LEN = 4;
    localparam logic [2:0] BURST_LAST = 3'h3;
    localparam logic [2:0] SINGLE_LAST = 3'h0;

    // bus states of the device end
    typedef enum logic [2:0] {
        ST_IDLE         = 3'b000,
        ST_ADDR         = 3'b001,
        ST_DATA_PHASE   = 3'b010,
        ST_PIPE_FIRST   = 3'b011,
        ST_PIPE_SECOND  = 3'b100
    } bus_state_e;

    // even parity per byte lane: lane i covers bits 8i+7..8i
    function automatic logic [LANES-1:0] even_par(
        input logic [DATA_W-1:0] d);
        logic [LANES-1:0] p;
        p = '0;
        for (int i = 0; i < LANES; i++) begin
            p[i] = ^d[i*8 +: 8]; // (RULE16) (RULE20)
        end
        return p;
    endfunction
endpackage

// >>> rtl/bus_dp_if.sv
// link between processor end and system end
// resolves the shared data and parity wires here; the processor end wins while its data enable is high
interface bus_dp_if;
    logic                            addr_strobe_n;
    logic                            data_code;
    logic                            write_cyc;
    logic                            cache_qual_n;
    logic [bus_dp_pkg::ADDR_W-1:0]   cyc_addr;
    logic                            bus_want_out;
    logic                            xfer_ready_n;
    logic                            bus_error_in_n;
    logic                            line_fill_enable_n;
    logic                            snoop_addr_strobe_n;
    logic [bus_dp_pkg::ADDR_W-1:0]   snoop_address;
    // data bus, one driver each end with enables
    logic [bus_dp_pkg::DATA_W-1:0]   cpu_data;
    logic                            cpu_data_oe;
    logic [bus_dp_pkg::LANES-1:0]    cpu_par;
    logic [bus_dp_pkg::DATA_W-1:0]   sys_data;
    logic                            sys_data_oe;
    logic [bus_dp_pkg::LANES-1:0]    sys_par;
    logic [bus_dp_pkg::DATA_W-1:0]   data_bus;
    logic [bus_dp_pkg::LANES-1:0]    byte_parity;

    assign data_bus    = cpu_data_oe ? cpu_data : sys_data;
    assign byte_parity = cpu_data_oe ? cpu_par : sys_par;

    modport cpu (
        output addr_strobe_n, data_code, write_cyc, cache_qual_n,
        output cyc_addr, bus_want_out, cpu_data, cpu_data_oe, cpu_par,
        input  xfer_ready_n, bus_error_in_n, line_fill_enable_n,
        input  snoop_addr_strobe_n, snoop_address, data_bus, byte_parity
    );
    modport sys (
        input  addr_strobe_n, data_code, write_cyc, cache_qual_n,
        input  cyc_addr, bus_want_out, data_bus, byte_parity, cpu_data_oe,
        output xfer_ready_n, bus_error_in_n, line_fill_enable_n,
        output snoop_addr_strobe_n, snoop_address,
        output sys_data, sys_data_oe, sys_par
    );
endinterface

// >>> rtl/bus_dp_cpu.sv
// processor end of the data phase: strobe, qualifiers, data, parity, check
// assumes one core clock, the partner obeys the link handshake
//
// Functional notes
// (RULE1) system asserts ready on valid or accepted data
// (RULE2) ready sampled only in data phase states
// (RULE3) bus want driven always from internal request; here only in ST_IDLE
// (RULE4) bus check captures address and control
// (RULE5) check plus enable raises machine check
// (RULE6) cache qualifier: cacheable read or writeback
// (RULE7) uncached read never fills the cache
// (RULE8) cache qualifier sets burst or single length
// (RULE9) everything on rising edge of one clock
// (RULE10) data/code valid with the address strobe
// (RULE11) 64 bit bus, lane 0 is low byte
// (RULE12) write data driven in data phase states
// (RULE13) read data captured on each ready
// (RULE14) even parity driven with write data
// (RULE15) system returns even parity with read data
// (RULE16) parity bit i covers byte lane i
// (RULE17) snoop strobe only with valid snoop address
// (RULE18) address strobe marks a new cycle
// (RULE19) snoop address on bits 31 to 5
// (RULE20) byte plus parity bit has even ones
module bus_dp_cpu (
    // clock and reset
    input  wire logic                          core_clk_in,
    input  wire logic                          sys_rst_in,
    // core request side
    input  wire logic                          req_valid_in,
    input  wire logic                          req_write_in,
    input  wire logic                          req_data_in,
    input  wire logic                          req_cacheable_in,
    input  wire logic [bus_dp_pkg::ADDR_W-1:0] req_addr_in,
    input  wire logic [bus_dp_pkg::DATA_W-1:0] req_wdata_in,
    input  wire logic                          machine_check_enable_in,
    output logic                               req_ready_out,
    output logic                               rdata_valid_out,
    output logic [bus_dp_pkg::DATA_W-1:0]      rdata_out,
    output logic                               rdata_par_err_out,
    output logic                               fill_cache_out,
    output logic                               cyc_done_out,
    output logic                               mc_valid_out,
    output logic [bus_dp_pkg::ADDR_W-1:0]      mc_addr_out,
    output logic [2:0]                         mc_ctrl_out,
    output logic                               mc_exception_out,
    output logic                               snoop_valid_out,
    output logic [bus_dp_pkg::ADDR_W-1:0]      snoop_addr_out,
    // link
    bus_dp_if.cpu                              bus
);
    typedef struct packed {
        bus_dp_pkg::bus_state_e          st;
        logic [2:0]                      beat;
        logic                            wr;
        logic                            dc;
        logic                            cache_n;
        logic                            fill;
        logic [bus_dp_pkg::ADDR_W-1:0]   addr;
        logic [bus_dp_pkg::DATA_W-1:0]   wdata;
        logic                            ads_n;
        logic                            want;
        logic                            oe;
        logic                            req_ready;
        logic                            rvalid;
        logic [bus_dp_pkg::DATA_W-1:0]   rdata;
        logic                            perr;
        logic                            fill_out;
        logic                            done;
        logic                            mc_valid;
        logic [bus_dp_pkg::ADDR_W-1:0]   mc_addr;
        logic [2:0]                      mc_ctrl;
        logic                            mc_exc;
        logic                            sn_valid;
        logic [bus_dp_pkg::ADDR_W-1:0]   sn_addr;
    } cpu_state_s;

    cpu_state_s s_reg;
    cpu_state_s s_next;
    logic       in_data;
    logic       last;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.rvalid = 1'b0;
        s_next.done = 1'b0;
        s_next.mc_exc = 1'b0;
        s_next.sn_valid = 1'b0;
        s_next.ads_n = 1'b1;
        s_next.req_ready = 1'b0;
        // ready only counts in the data phase states
        in_data = (s_reg.st == bus_dp_pkg::ST_DATA_PHASE) ||
                  (s_reg.st == bus_dp_pkg::ST_PIPE_FIRST) ||
                  (s_reg.st == bus_dp_pkg::ST_PIPE_SECOND); // (RULE2)
        // cycle length from the cache qualifier alone
        last = s_reg.cache_n ? (s_reg.beat == bus_dp_pkg::SINGLE_LAST)
                             : (s_reg.beat == bus_dp_pkg::BURST_LAST); // (RULE8)
        s_next.want = req_valid_in && (s_reg.st == bus_dp_pkg::ST_IDLE); // (RULE3)
        case (s_reg.st)
            bus_dp_pkg::ST_IDLE: begin
                if (req_valid_in) begin
                    s_next.st = bus_dp_pkg::ST_ADDR;
                    s_next.ads_n = 1'b0; // (RULE18)
                    s_next.dc = req_data_in; // (RULE10)
                    s_next.wr = req_write_in;
                    // read: cacheable; write: writeback burst
                    s_next.cache_n = ~req_cacheable_in; // (RULE6)
                    s_next.addr = req_addr_in;
                    s_next.wdata = req_wdata_in;
                    s_next.beat = 3'h0;
                    s_next.fill = 1'b1;
                    s_next.req_ready = 1'b1;
                end
            end
            bus_dp_pkg::ST_ADDR: begin
                s_next.st = bus_dp_pkg::ST_DATA_PHASE;
                s_next.oe = s_reg.wr; // (RULE12)
            end
            bus_dp_pkg::ST_DATA_PHASE, bus_dp_pkg::ST_PIPE_FIRST,
            bus_dp_pkg::ST_PIPE_SECOND: begin
                if (in_data && !bus.xfer_ready_n) begin
                    if (!s_reg.wr) begin
                        s_next.rvalid = 1'b1;
                        s_next.rdata = bus.data_bus; // (RULE13)
                        // odd ones in any lane means bad even parity
                        s_next.perr = |(bus_dp_pkg::even_par(bus.data_bus)
                                        ^ bus.byte_parity); // (RULE15)
                        // uncached read never allocates
                        if (s_reg.beat == 3'h0) begin
                            s_next.fill = ~s_reg.cache_n
                                          & ~bus.line_fill_enable_n; // (RULE7)
                        end
                        s_next.fill_out = s_next.fill;
                    end
                    if (!bus.bus_error_in_n) begin
                        s_next.mc_valid = 1'b1;
                        s_next.mc_addr = s_reg.addr; // (RULE4)
                        s_next.mc_ctrl = {s_reg.wr, s_reg.dc, s_reg.cache_n};
                        s_next.mc_exc = machine_check_enable_in; // (RULE5)
                    end
                    if (last) begin
                        s_next.st = bus_dp_pkg::ST_IDLE;
                        s_next.oe = 1'b0;
                        s_next.done = 1'b1;
                    end else begin
                        s_next.beat = s_reg.beat + 3'h1;
                        s_next.st = (s_reg.st == bus_dp_pkg::ST_DATA_PHASE)
                                    ? bus_dp_pkg::ST_PIPE_FIRST
                                    : bus_dp_pkg::ST_PIPE_SECOND;
                    end
                end
            end
            default: s_next.st = bus_dp_pkg::ST_IDLE;
        endcase
        if (!bus.snoop_addr_strobe_n) begin
            s_next.sn_valid = 1'b1;
            s_next.sn_addr = {bus.snoop_address[bus_dp_pkg::ADDR_W-1:
                                                bus_dp_pkg::SNOOP_LO],
                              {bus_dp_pkg::SNOOP_LO{1'b0}}}; // (RULE19)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // all state moves on the rising edge
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin // (RULE9)
        if (sys_rst_in) begin
            s_reg <= '0;
            s_reg.ads_n <= 1'b1;
            s_reg.cache_n <= 1'b1;
            s_reg.st <= bus_dp_pkg::ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link and user outputs straight from flops, except write parity, which is worked out from the held write data
    assign bus.addr_strobe_n = s_reg.ads_n;
    assign bus.data_code     = s_reg.dc;
    assign bus.write_cyc     = s_reg.wr;
    assign bus.cache_qual_n  = s_reg.cache_n;
    assign bus.cyc_addr      = s_reg.addr;
    assign bus.bus_want_out  = s_reg.want; // (RULE3)
    assign bus.cpu_data      = s_reg.wdata; // (RULE11)
    assign bus.cpu_data_oe   = s_reg.oe;
    // parity travels in the same clock as the write data
    assign bus.cpu_par       = bus_dp_pkg::even_par(s_reg.wdata); // (RULE14)
    assign req_ready_out     = s_reg.req_ready;
    assign rdata_valid_out   = s_reg.rvalid;
    assign rdata_out         = s_reg.rdata;
    assign rdata_par_err_out = s_reg.perr;
    assign fill_cache_out    = s_reg.fill_out;
    assign cyc_done_out      = s_reg.done;
    assign mc_valid_out      = s_reg.mc_valid;
    assign mc_addr_out       = s_reg.mc_addr;
    assign mc_ctrl_out       = s_reg.mc_ctrl;
    assign mc_exception_out  = s_reg.mc_exc;
    assign snoop_valid_out   = s_reg.sn_valid;
    assign snoop_addr_out    = s_reg.sn_addr;
endmodule

// >>> rtl/bus_dp_sys.sv
// system end: answers cycles with ready, data and parity; issues snoops
// assumes the user side holds read data and a snoop request as levels
module bus_dp_sys (
    // clock and reset
    input  wire logic                          core_clk_in,
    input  wire logic                          sys_rst_in,
    // user side
    input  wire logic [bus_dp_pkg::DATA_W-1:0] rd_data_in,
    input  wire logic                          bus_error_in,
    input  wire logic                          fill_ok_in,
    input  wire logic                          snoop_req_in,
    input  wire logic [bus_dp_pkg::ADDR_W-1:0] snoop_addr_in,
    output logic                               wr_valid_out,
    output logic [bus_dp_pkg::DATA_W-1:0]      wr_data_out,
    output logic                               cyc_start_out,
    output logic [bus_dp_pkg::ADDR_W-1:0]      cyc_addr_out,
    output logic                               bus_want_seen_out,
    // link
    bus_dp_if.sys                              bus
);
    typedef struct packed {
        logic                            active;
        logic                            wr;
        logic [2:0]                      beat;
        logic [2:0]                      last;
        logic                            rdy_n;
        logic                            oe;
        logic [bus_dp_pkg::DATA_W-1:0]   d;
        logic                            err_n;
        logic                            ken_n;
        logic                            snoop_addr_strobe_n_n;
        logic [bus_dp_pkg::ADDR_W-1:0]   sa;
        logic                            wv;
        logic [bus_dp_pkg::DATA_W-1:0]   wd;
        logic                            start;
        logic [bus_dp_pkg::ADDR_W-1:0]   ca;
        logic                            want;
    } sys_state_s;

    sys_state_s s_reg;
    sys_state_s s_next;

    ////////////////////////////////////////////////////////////////////////
    // answer one beat per clock after the strobe
    always_comb begin
        s_next = s_reg;
        s_next.rdy_n = 1'b1;
        s_next.oe = 1'b0;
        s_next.err_n = 1'b1;
        s_next.wv = 1'b0;
        s_next.start = 1'b0;
        s_next.snoop_addr_strobe_n_n = 1'b1;
        s_next.want = bus.bus_want_out;
        if (!bus.addr_strobe_n) begin
            s_next.active = 1'b1;
            s_next.wr = bus.write_cyc;
            s_next.beat = 3'h0;
            // length derived from the cache qualifier
            s_next.last = bus.cache_qual_n ? bus_dp_pkg::SINGLE_LAST
                                           : bus_dp_pkg::BURST_LAST; // (RULE8)
            s_next.start = 1'b1;
            s_next.ca = bus.cyc_addr;
        end else if (s_reg.active) begin
            // ready with valid read data or on accepting write data
            s_next.rdy_n = 1'b0; // (RULE1)
            s_next.err_n = ~bus_error_in;
            s_next.ken_n = ~fill_ok_in;
            s_next.oe = ~s_reg.wr;
            s_next.d = rd_data_in;
            if (s_reg.rdy_n == 1'b0) begin
                if (s_reg.wr) begin
                    s_next.wv = 1'b1;
                    s_next.wd = bus.data_bus;
                end
                if (s_reg.beat == s_reg.last) begin
                    s_next.active = 1'b0;
                    s_next.rdy_n = 1'b1;
                    s_next.oe = 1'b0;
                    s_next.err_n = 1'b1;
                end else begin
                    s_next.beat = s_reg.beat + 3'h1;
                end
            end
        end
        // strobe only together with a held snoop address
        if (snoop_req_in && s_reg.snoop_addr_strobe_n_n) begin
            s_next.snoop_addr_strobe_n_n = 1'b0; // (RULE17)
            s_next.sa = {snoop_addr_in[bus_dp_pkg::ADDR_W-1:
                                       bus_dp_pkg::SNOOP_LO],
                         {bus_dp_pkg::SNOOP_LO{1'b0}}}; // (RULE19)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers on the rising edge
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin // (RULE9)
        if (sys_rst_in) begin
            s_reg <= '0;
            s_reg.rdy_n <= 1'b1;
            s_reg.err_n <= 1'b1;
            s_reg.ken_n <= 1'b1;
            s_reg.snoop_addr_strobe_n_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign bus.xfer_ready_n        = s_reg.rdy_n;
    assign bus.bus_error_in_n      = s_reg.err_n;
    assign bus.line_fill_enable_n  = s_reg.ken_n;
    assign bus.snoop_addr_strobe_n = s_reg.snoop_addr_strobe_n_n;
    assign bus.snoop_address       = s_reg.sa;
    assign bus.sys_data            = s_reg.d; // (RULE11)
    assign bus.sys_data_oe         = s_reg.oe;
    // parity with the read data, same clock
    assign bus.sys_par = bus_dp_pkg::even_par(s_reg.d); // (RULE15)
    assign wr_valid_out      = s_reg.wv;
    assign wr_data_out       = s_reg.wd;
    assign cyc_start_out     = s_reg.start;
    assign cyc_addr_out      = s_reg.ca;
    assign bus_want_seen_out = s_reg.want;
endmodule

// >>> verif/bus_dp_asserts.sv
// checker for the link between the processor end and the system end
// assumes it sits beside bus_dp_if and sees its signals by name
module bus_dp_asserts (
    // clock and reset
    input wire logic                          core_clk_in,
    input wire logic                          sys_rst_in,
    // link signals
    input wire logic                          addr_strobe_n,
    input wire logic                          data_code,
    input wire logic                          write_cyc,
    input wire logic                          cache_qual_n,
    input wire logic [bus_dp_pkg::ADDR_W-1:0] cyc_addr,
    input wire logic                          bus_want_out,
    input wire logic                          xfer_ready_n,
    input wire logic                          cpu_data_oe,
    input wire logic [bus_dp_pkg::DATA_W-1:0] data_bus,
    input wire logic [bus_dp_pkg::LANES-1:0]  byte_parity,
    input wire logic                          snoop_addr_strobe_n
);
    logic [7:0] lane_par;

    // parity worked out here per lane, never borrowed from the design
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lane_par[i] = ^data_bus[8*i +: 8];
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    ////////////////////////////////////////////////////////////////////
    // the steps of one cycle
    sequence strobe_gap;
        addr_strobe_n && xfer_ready_n;
    endsequence
    sequence burst_beats;
        !xfer_ready_n [*4] ##1 xfer_ready_n;
    endsequence
    sequence single_beat;
        !xfer_ready_n ##1 xfer_ready_n;
    endsequence

    strobe_pulse_a: assert property (!addr_strobe_n |=> strobe_gap)
        else $error("address strobe not a single pulse");
    burst_len_a: assert property (!addr_strobe_n && !cache_qual_n |-> ##2 burst_beats)
        else $error("cacheable cycle not four beats");
    single_len_a: assert property (!addr_strobe_n && cache_qual_n |-> ##2 single_beat)
        else $error("uncached cycle not one beat");
    write_drive_a: assert property (!addr_strobe_n && write_cyc |=> cpu_data_oe [*2])
        else $error("write data not driven in data phase");
    write_ready_a: assert property (!xfer_ready_n && write_cyc |-> cpu_data_oe)
        else $error("write beat without processor data");
    par_even_a: assert property (cpu_data_oe || !xfer_ready_n |-> byte_parity == lane_par)
        else $error("byte parity not even");
    qual_hold_a: assert property (!xfer_ready_n |-> $stable(data_code) && $stable(write_cyc) && $stable(cyc_addr))
        else $error("cycle qualifiers moved in data phase");
    want_busy_a: assert property (!xfer_ready_n |-> !bus_want_out)
        else $error("bus want raised while cycle open");
    no_overlap_a: assert property (!xfer_ready_n |-> addr_strobe_n)
        else $error("new strobe during data beats");
    snoop_pulse_a: assert property (!snoop_addr_strobe_n |=> snoop_addr_strobe_n)
        else $error("snoop strobe longer than one clock");
endmodule

// >>> verif/cpu_bus_data_phase_tb.sv
// self-checking bench: both ends joined, plus a lone processor end
// assumes the design files and bus_dp_pkg are compiled first
module cpu_bus_data_phase_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk_in, sys_rst_in, req_valid, req2_valid, machine_check_enable;
    logic        req_write, req_data, req_cache, fill_ok, bus_error;
    logic        snoop_req, r_rdy, r_val, r_perr, r_fill, r_done, mc_v;
    logic        mc_exc, sn_v, w_val, c_start, r2_rdy, r2_val, r2_perr, w_seen;
    logic [2:0]  mc_ctrl;
    logic [31:0] req_addr, snoop_addr, mc_addr, sn_addr, c_addr, cur_addr;
    logic [63:0] req_wdata, rd_data, r_data, w_data;
    logic [31:0] rng = 32'h0146_619b;
    logic [65:0] exp_q[$];
    int          err_count = 0, checked = 0, exc_cnt = 0, r2_cnt = 0, wc = 0;

    bus_dp_if bus ();
    bus_dp_if bus2 ();
    bus_dp_cpu bus_dp_cpu_inst (.core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in), .req_valid_in(req_valid),
        .req_write_in(req_write), .req_data_in(req_data),
        .req_cacheable_in(req_cache), .req_addr_in(req_addr),
        .req_wdata_in(req_wdata), .machine_check_enable_in(machine_check_enable),
        .req_ready_out(r_rdy), .rdata_valid_out(r_val), .rdata_out(r_data),
        .rdata_par_err_out(r_perr), .fill_cache_out(r_fill),
        .cyc_done_out(r_done), .mc_valid_out(mc_v), .mc_addr_out(mc_addr),
        .mc_ctrl_out(mc_ctrl), .mc_exception_out(mc_exc),
        .snoop_valid_out(sn_v), .snoop_addr_out(sn_addr), .bus(bus.cpu));
    bus_dp_sys bus_dp_sys_inst (.core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in), .rd_data_in(rd_data),
        .bus_error_in(bus_error), .fill_ok_in(fill_ok),
        .snoop_req_in(snoop_req), .snoop_addr_in(snoop_addr),
        .wr_valid_out(w_val), .wr_data_out(w_data), .cyc_start_out(c_start),
        .cyc_addr_out(c_addr), .bus_want_seen_out(w_seen), .bus(bus.sys));
    // second processor end faces the bench, which misbehaves on purpose
    bus_dp_cpu bus_dp_cpu_inst2 (.core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in), .req_valid_in(req2_valid),
        .req_write_in(req_write), .req_data_in(req_data),
        .req_cacheable_in(req_cache), .req_addr_in(req_addr),
        .req_wdata_in(req_wdata), .machine_check_enable_in(machine_check_enable),
        .req_ready_out(r2_rdy), .rdata_valid_out(r2_val), .rdata_out(),
        .rdata_par_err_out(r2_perr), .fill_cache_out(), .cyc_done_out(),
        .mc_valid_out(), .mc_addr_out(), .mc_ctrl_out(),
        .mc_exception_out(), .snoop_valid_out(), .snoop_addr_out(),
        .bus(bus2.cpu));
    bus_dp_asserts bus_dp_asserts_inst (.core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in), .addr_strobe_n(bus.addr_strobe_n),
        .data_code(bus.data_code), .write_cyc(bus.write_cyc),
        .cache_qual_n(bus.cache_qual_n), .cyc_addr(bus.cyc_addr),
        .bus_want_out(bus.bus_want_out), .xfer_ready_n(bus.xfer_ready_n),
        .cpu_data_oe(bus.cpu_data_oe), .data_bus(bus.data_bus),
        .byte_parity(bus.byte_parity),
        .snoop_addr_strobe_n(bus.snoop_addr_strobe_n));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [65:0] pop();
        if (exp_q.size() == 0)
            return 'x;
        return exp_q.pop_front();
    endfunction
    task automatic chk(input logic [65:0] got, input logic [65:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge core_clk_in);
        #1;
    endtask
    // bounded wait, so a dead handshake cannot hang the run
    task automatic wait_hi(ref logic s);
        int k;
        k = 0;
        do begin
            step();
            k++;
        end while (s !== 1'b1 && k < 50);
        chk({65'h0, s}, 66'h1);
    endtask
    task automatic do_reset();
        sys_rst_in = 1'b1;
        repeat (3) @(posedge core_clk_in);
        #1;
        sys_rst_in = 1'b0;
    endtask
    // one whole cycle; expected beats noted before the request goes out
    task automatic run_cyc(input logic wr, input logic dc, input logic ca);
        cur_addr = rnd();
        req_addr = cur_addr;
        req_wdata = {rnd(), rnd()};
        rd_data = {rnd(), rnd()};
        fill_ok = rnd() > 32'h7fff_ffff;
        {req_write, req_data, req_cache} = {wr, dc, ca};
        for (int i = 0; i < (ca ? 4 : 1); i++)
            exp_q.push_back(wr ? {2'b0, req_wdata} : {1'b0, ca & fill_ok, rd_data});
        req_valid = 1'b1;
        wait_hi(r_rdy);
        req_valid = 1'b0;
        wait_hi(r_done);
        step();
    endtask
    task automatic bus_check(input logic en);
        int e0;
        e0 = exc_cnt;
        machine_check_enable = en;
        bus_error = 1'b1;
        run_cyc(1'b1, 1'b1, 1'b0);
        bus_error = 1'b0;
        chk({30'h0, mc_v, mc_ctrl, mc_addr}, {30'h0, 4'hf, cur_addr});
        chk(66'(exc_cnt - e0), 66'(en));
    endtask
    task automatic conclude();
        $display("counts: checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // result watcher: each read, write or snoop result takes the oldest note
    always @(posedge core_clk_in) begin
        if (r_val === 1'b1)
            chk({r_perr, r_fill, r_data}, pop());
        if (w_val === 1'b1)
            chk({2'b0, w_data}, pop());
        if (sn_v === 1'b1)
            chk({34'h0, sn_addr}, pop());
        if (c_start === 1'b1)
            chk({34'h0, c_addr}, {34'h0, cur_addr});
        if (mc_exc === 1'b1)
            exc_cnt++;
        if (r2_val === 1'b1)
            r2_cnt++;
        if (w_seen === 1'b1)
            wc++;
    end

    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    // watchdog sized well past the roughly 140 cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk_in);
        err_count++;
        conclude();
    end

    initial begin
        {sys_rst_in, req_valid, req2_valid, machine_check_enable} = 4'b1000;
        {req_write, req_data, req_cache, fill_ok, bus_error, snoop_req} = '0;
        {req_addr, snoop_addr, req_wdata, rd_data} = '0;
        {bus2.xfer_ready_n, bus2.bus_error_in_n} = 2'b11;
        {bus2.line_fill_enable_n, bus2.snoop_addr_strobe_n} = 2'b11;
        {bus2.snoop_address, bus2.sys_data, bus2.sys_par} = '0;
        bus2.sys_data_oe = 1'b0;
        do_reset();
        for (int i = 0; i < 16; i++)
            run_cyc(i[0], i[2], i[1]);
        $display("test cycles done");
        for (int i = 0; i < 3; i++) begin
            snoop_addr = rnd();
            exp_q.push_back({34'h0, snoop_addr & 32'hffff_ffe0});
            snoop_req = 1'b1;
            step();
            snoop_req = 1'b0;
            wait_hi(sn_v);
            repeat (2) step();
        end
        $display("test snoop done");
        do_reset();
        bus_check(1'b0);
        do_reset();
        bus_check(1'b1);
        chk(66'(wc), 66'h12);
        $display("test bus check done");
        {req_write, req_data, req_cache} = 3'b010;
        req2_valid = 1'b1;
        wait_hi(r2_rdy);
        req2_valid = 1'b0;
        bus2.xfer_ready_n = 1'b0; // early ready, must be ignored
        step();
        bus2.xfer_ready_n = 1'b1;
        step();
        {bus2.xfer_ready_n, bus2.sys_data_oe} = 2'b01;
        {bus2.sys_data, bus2.sys_par} = {64'h0000_0000_0000_0001, 8'h00};
        step();
        {bus2.xfer_ready_n, bus2.sys_data_oe} = 2'b10;
        bus2.sys_data = ~bus2.sys_data;
        chk({64'h0, r2_val, r2_perr}, 66'h3);
        repeat (4) step();
        chk(66'(r2_cnt), 66'h1);
        $display("test fault end done");
        conclude();
    end
endmodule
